// >>> switch_reset_unlock_control.sv
// switch global control low bits: reset triggers and unlock controls
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module switch_reset_unlock_control
  import switch_reset_unlock_pkg::*;
#(
  parameter int NUM_PBDV = PBDV_COUNT
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire reg_req_s reg_req_i,
  input wire logic reset_seq_active_i,
  input wire logic hot_reset_cause_i,
  input wire logic upstream_dl_down_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic wr_cpl_o,
  output reset_req_s reset_req_o,
  output logic lockable_write_enable_o,
  output logic power_budget_write_enable_o,
  output logic linkdown_reset_suppress_o
);

  localparam int IDX_W = (NUM_PBDV > 1) ? $clog2(NUM_PBDV) : 1;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  function automatic logic pbdv_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - PBDV_BASE_OFF;
    pbdv_hit = (a >= PBDV_BASE_OFF) && (off[1:0] == 2'h0) &&
               (off[ADDR_W-1:2] < (ADDR_W-2)'(NUM_PBDV));
  endfunction

  function automatic logic [IDX_W-1:0] pbdv_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - PBDV_BASE_OFF;
    pbdv_idx = off[IDX_W+1:2];
  endfunction

  // state
  logic lock_we_r;
  logic lock_we_nxt;
  logic pb_we_r;
  logic pb_we_nxt;
  logic ld_suppress_r;
  logic ld_suppress_nxt;
  logic full_pend_r;
  logic warm_pend_r;
  logic cpl_r;
  logic dl_down_d_r;
  reset_req_s reset_req_r;
  reset_req_s reset_req_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic [NUM_PBDV-1:0][DATA_W-1:0] pbdv_r;

  // decode
  wire ctl_hit = (reg_req_i.addr == SWITCH_GLOBAL_CONTROL_OFF);
  wire ctl_wr = reg_req_i.wr && ctl_hit;
  wire pb_hit = pbdv_hit(reg_req_i.addr);
  wire [IDX_W-1:0] pb_idx = pbdv_idx(reg_req_i.addr);
  wire pb_wr = reg_req_i.wr && pb_hit && pb_we_r;
  wire full_trig = ctl_wr && reg_req_i.wdata[FULL_RESET_BIT];
  wire warm_trig = ctl_wr && reg_req_i.wdata[WARM_RESET_BIT];
  wire dl_rise = upstream_dl_down_i && !dl_down_d_r;

  // sequencer set wins over a software clear in the same cycle
  assign lock_we_nxt = reset_seq_active_i ? 1'b1 :
                       ctl_wr ? reg_req_i.wdata[LOCK_WE_BIT] :
                       lock_we_r;

  // bit 4 is itself lockable, so it only moves while unlocked
  assign pb_we_nxt = (ctl_wr && lock_we_r) ?
                     reg_req_i.wdata[PB_WE_BIT] : pb_we_r;

  assign ld_suppress_nxt = ctl_wr ? reg_req_i.wdata[LD_SUPPRESS_BIT] :
                           ld_suppress_r;

  // a link-down only counts on its rising edge and only if not suppressed
  assign reset_req_nxt.full = full_pend_r;
  assign reset_req_nxt.warm = warm_pend_r || hot_reset_cause_i ||
                              (dl_rise && !ld_suppress_r);
  assign reset_req_nxt.retrain = warm_pend_r;

  // trigger bits and reserved bit never read back as one
  wire [DATA_W-1:0] ctl_rd = {
    {(DATA_W-6){1'b0}},
    ld_suppress_r,
    pb_we_r,
    lock_we_r,
    3'h0
  };

  assign rd_data_nxt = !reg_req_i.rd ? UNMAPPED_RD :
                       ctl_hit ? ctl_rd :
                       pb_hit ? pbdv_r[pb_idx] :
                       UNMAPPED_RD;

  // only reset_i clears sticky bits; hot reset causes never touch them
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      lock_we_r <= LOCK_WE_RST;
      pb_we_r <= PB_WE_RST;
      ld_suppress_r <= LD_SUPPRESS_RST;
    end else begin
      lock_we_r <= lock_we_nxt;
      pb_we_r <= pb_we_nxt;
      ld_suppress_r <= ld_suppress_nxt;
    end
  end

  // completion leaves one cycle ahead of the reset request
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      full_pend_r <= 1'b0;
      warm_pend_r <= 1'b0;
      cpl_r <= 1'b0;
      dl_down_d_r <= 1'b0;
      reset_req_r <= '0;
      rd_data_r <= UNMAPPED_RD;
    end else begin
      full_pend_r <= full_trig;
      warm_pend_r <= warm_trig;
      cpl_r <= reg_req_i.wr;
      dl_down_d_r <= upstream_dl_down_i;
      reset_req_r <= reset_req_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // contents are undefined after reset in the real part; zero is chosen
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pbdv_r <= {NUM_PBDV{PBDV_RST}};
    end else if (pb_wr) begin
      pbdv_r[pb_idx] <= reg_req_i.wdata;
    end
  end

  assign rd_data_o = rd_data_r;
  assign wr_cpl_o = cpl_r;
  assign reset_req_o = reset_req_r;
  assign lockable_write_enable_o = lock_we_r;
  assign power_budget_write_enable_o = pb_we_r;
  assign linkdown_reset_suppress_o = ld_suppress_r;

  // checks

  a_full_after_cpl: assert property (
    full_trig && !full_pend_r |=>
    (wr_cpl_o && !reset_req_o.full) ##1 reset_req_o.full)
    else $error("fundamental reset not after completion");

  a_full_cause: assert property (
    reset_req_o.full |-> $past(full_trig, 2))
    else $error("fundamental reset without a trigger write");

  a_warm_retrain: assert property (
    warm_trig |=> wr_cpl_o ##1 (reset_req_o.warm && reset_req_o.retrain))
    else $error("hot reset trigger missed retrain or warm");

  a_retrain_cause: assert property (
    reset_req_o.retrain |-> $past(warm_trig, 2))
    else $error("retrain without hot reset trigger");

  a_trig_read_zero: assert property (
    $past(reg_req_i.rd) && $past(ctl_hit) |-> rd_data_o[1:0] == 2'h0)
    else $error("trigger bits read back as one");

  a_reserved_zero: assert property (
    $past(reg_req_i.rd) && $past(ctl_hit) |-> !rd_data_o[RESERVED_BIT])
    else $error("reserved bit read as one");

  a_lock_update: assert property (
    ctl_wr && lock_we_r |=> pb_we_r == $past(reg_req_i.wdata[PB_WE_BIT]))
    else $error("unlocked field did not take write");

  a_lock_hold: assert property (
    ctl_wr && !lock_we_r |=> $stable(pb_we_r))
    else $error("locked field changed on write");

  a_unlock_seq: assert property (
    reset_seq_active_i |=> lockable_write_enable_o)
    else $error("unlock bit not set by reset sequence");

  a_pbdv_write: assert property (
    pb_wr |=> pbdv_r[$past(pb_idx)] == $past(reg_req_i.wdata))
    else $error("power budget data not written while open");

  a_pbdv_ignore: assert property (
    reg_req_i.wr && pb_hit && !pb_we_r |=> $stable(pbdv_r))
    else $error("power budget data written while closed");

  a_linkdown_mask: assert property (
    dl_rise && ld_suppress_r && !warm_pend_r && !hot_reset_cause_i
    |=> !reset_req_o.warm)
    else $error("link down caused hot reset while suppressed");

  a_linkdown_fire: assert property (
    dl_rise && !ld_suppress_r |=> reset_req_o.warm)
    else $error("link down hot reset missing");

  a_other_cause: assert property (
    hot_reset_cause_i |=> reset_req_o.warm)
    else $error("other hot reset cause blocked");

  a_hot_sticky: assert property (
    hot_reset_cause_i && !ctl_wr && !reset_seq_active_i
    |=> $stable(ld_suppress_r) && $stable(lock_we_r) && $stable(pb_we_r))
    else $error("sticky bit changed on hot reset");

  a_full_zero_write: assert property (
    ctl_wr && !reg_req_i.wdata[FULL_RESET_BIT] |-> ##2 !reset_req_o.full)
    else $error("fundamental reset from a zero write");

  a_warm_zero_write: assert property (
    ctl_wr && !reg_req_i.wdata[WARM_RESET_BIT] |-> ##2 !reset_req_o.retrain)
    else $error("retrain from a zero write");

  a_retrain_with_warm: assert property (
    reset_req_o.retrain |-> reset_req_o.warm)
    else $error("retrain without hot reset");

  a_cpl_every_write: assert property (
    reg_req_i.wr |=> wr_cpl_o)
    else $error("write without completion");

  a_cpl_only_write: assert property (
    wr_cpl_o |-> $past(reg_req_i.wr))
    else $error("completion without a write");

  a_full_needs_cpl: assert property (
    reset_req_o.full |-> $past(wr_cpl_o))
    else $error("fundamental reset not preceded by completion");

  a_warm_needs_cpl: assert property (
    reset_req_o.retrain |-> $past(wr_cpl_o))
    else $error("hot reset trigger not preceded by completion");

  a_unlock_write: assert property (
    ctl_wr && !reset_seq_active_i |=>
    lock_we_r == $past(reg_req_i.wdata[LOCK_WE_BIT]))
    else $error("unlock bit did not take write");

  a_unlock_hold: assert property (
    !ctl_wr && !reset_seq_active_i |=> $stable(lock_we_r))
    else $error("unlock bit moved without cause");

  a_pb_stable_locked: assert property (
    !lock_we_r |=> $stable(pb_we_r))
    else $error("locked power budget enable changed");

  a_pbdv_closed_hold: assert property (
    !pb_we_r |=> $stable(pbdv_r))
    else $error("power budget data moved while closed");

  a_pbdv_read: assert property (
    $past(reg_req_i.rd) && $past(pb_hit) |->
    rd_data_o == $past(pbdv_r[pb_idx]))
    else $error("power budget data read wrong");

  a_linkdown_level: assert property (
    upstream_dl_down_i && dl_down_d_r && !hot_reset_cause_i && !warm_pend_r
    |=> !reset_req_o.warm)
    else $error("held link down repeated hot reset");

  a_suppress_hold: assert property (
    !ctl_wr |=> $stable(ld_suppress_r))
    else $error("link down disable bit moved without write");

  a_suppress_write: assert property (
    ctl_wr |=> ld_suppress_r == $past(reg_req_i.wdata[LD_SUPPRESS_BIT]))
    else $error("link down disable bit did not take write");

  a_other_masked: assert property (
    hot_reset_cause_i && ld_suppress_r |=> reset_req_o.warm)
    else $error("other hot reset cause blocked by disable bit");

  a_warm_trig_masked: assert property (
    warm_trig && ld_suppress_r |-> ##2 reset_req_o.warm)
    else $error("hot reset trigger blocked by disable bit");

  a_reserved_high: assert property (
    $past(reg_req_i.rd) && $past(ctl_hit) |->
    rd_data_o[DATA_W-1:LD_SUPPRESS_BIT+1] == '0)
    else $error("upper control bits read as one");

  a_ctl_fields: assert property (
    $past(reg_req_i.rd) && $past(ctl_hit) |->
    rd_data_o[LD_SUPPRESS_BIT:LOCK_WE_BIT] ==
    $past({ld_suppress_r, pb_we_r, lock_we_r}))
    else $error("control fields read back wrong");

  a_hot_no_clear: assert property (
    hot_reset_cause_i && !pb_wr |=> $stable(pbdv_r))
    else $error("hot reset changed power budget data");

  a_unmapped_read: assert property (
    $past(reg_req_i.rd) && !$past(ctl_hit) && !$past(pb_hit) |->
    rd_data_o == UNMAPPED_RD)
    else $error("unmapped read returned data");

  a_rd_idle_zero: assert property (
    !$past(reg_req_i.rd) |-> rd_data_o == UNMAPPED_RD)
    else $error("read data outside its cycle");

  c_full_reset: cover property (full_trig ##2 reset_req_o.full);
  c_warm_reset: cover property (warm_trig ##2 reset_req_o.retrain);
  c_pbdv_open_write: cover property (pb_wr);
  c_linkdown_masked: cover property (dl_rise && ld_suppress_r);
  c_seq_unlock: cover property (reset_seq_active_i ##1 lockable_write_enable_o);

endmodule

`default_nettype wire

// >>> switch_reset_unlock_pkg.sv
// constants and carrier types for the switch reset and unlock control bank
// Operation
// - writing one to bit 0 starts fundamental reset; bit reads zero
// - writing one to bit 1 starts hot reset plus upstream link retrain
// - completion for a trigger write goes out before the reset acts
// - unlock bit 3 set lets writes update lockable fields
// - unlock bit 3 clear makes every lockable field hold on writes
// - unlock bit resets to zero, sticky, set during reset sequence
// - bit 4 opens power budget data registers; bit 4 is lockable
// - bit 5 set stops hot reset on upstream data link down
// - bit 5 leaves other hot reset causes alone; resets zero, sticky
// - power budget data writes are ignored while bit 4 is clear
package switch_reset_unlock_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] SWITCH_GLOBAL_CONTROL_OFF = 12'h404;
  localparam logic [ADDR_W-1:0] PBDV_BASE_OFF = 12'h300;
  localparam int PBDV_COUNT = 8;

  localparam int FULL_RESET_BIT = 0;
  localparam int WARM_RESET_BIT = 1;
  localparam int RESERVED_BIT = 2;
  localparam int LOCK_WE_BIT = 3;
  localparam int PB_WE_BIT = 4;
  localparam int LD_SUPPRESS_BIT = 5;

  localparam logic LOCK_WE_RST = 1'b0;
  localparam logic PB_WE_RST = 1'b0;
  localparam logic LD_SUPPRESS_RST = 1'b0;
  localparam logic [DATA_W-1:0] PBDV_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

  // cycles from write acceptance to completion, and completion to reset
  localparam int CPL_DELAY_CYC = 1;
  localparam int RESET_AFTER_CPL_CYC = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic full;
    logic warm;
    logic retrain;
  } reset_req_s;

endpackage

// >>> config_requester.sv
// requester model issuing register reads and writes to the bank
`timescale 1ns/1ps
`default_nettype none
module config_requester
  import switch_reset_unlock_pkg::*;
(
  input wire logic sys_clk_i,
  output var reg_req_s reg_req_o,
  input wire logic [DATA_W-1:0] rd_data_i
);
  logic [DATA_W-1:0] last_rd;
  initial reg_req_o = '0;
  // idle lines invert so a stale value never looks current
  task automatic cycle(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic w);
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic write(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
    cycle(a, d, 1'b1);
  endtask
  // data stands only in the cycle after the strobe
  task automatic read(input logic [ADDR_W-1:0] a);
    cycle(a, '0, 1'b0);
    #1;
    last_rd = rd_data_i;
  endtask
endmodule
`default_nettype wire

// >>> tb_switch_reset_unlock_control.sv
// testbench for the switch reset and unlock control bank
`timescale 1ns/1ps
`default_nettype none
module tb_switch_reset_unlock_control;
  import switch_reset_unlock_pkg::*;
  localparam logic [ADDR_W-1:0] CTL = SWITCH_GLOBAL_CONTROL_OFF;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic seq_act = 1'b0;
  logic hot_cause = 1'b0;
  logic dl_down = 1'b0;
  reg_req_s req;
  logic [DATA_W-1:0] rd_data;
  logic cpl;
  logic lock_we;
  logic pb_we;
  logic ld_sup;
  reset_req_s rst_req;
  int miscompares = 0;
  int checked = 0;
  int i;
  logic [ADDR_W-1:0] pa;
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  config_requester config_requester_i(.sys_clk_i(sys_clk_i),
    .reg_req_o(req), .rd_data_i(rd_data));
  switch_reset_unlock_control switch_reset_unlock_control_i(
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_req_i(req),
    .reset_seq_active_i(seq_act), .hot_reset_cause_i(hot_cause),
    .upstream_dl_down_i(dl_down), .rd_data_o(rd_data), .wr_cpl_o(cpl),
    .reset_req_o(rst_req), .lockable_write_enable_o(lock_we),
    .power_budget_write_enable_o(pb_we),
    .linkdown_reset_suppress_o(ld_sup));
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    checked++;
    if (got !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    config_requester_i.read(a);
    chk(config_requester_i.last_rd, e);
  endtask
  // completion first, reset request one cycle later
  task automatic trig(input logic [DATA_W-1:0] d, input logic [2:0] e);
    config_requester_i.write(CTL, d);
    #1;
    chk({31'h0, cpl}, 32'h1);
    chk({29'h0, rst_req}, 32'h0);
    @(posedge sys_clk_i);
    #1;
    chk({29'h0, rst_req}, {29'h0, e});
  endtask
  task automatic pulse(input logic hot, input logic e);
    @(posedge sys_clk_i);
    hot_cause <= hot;
    dl_down <= !hot;
    @(posedge sys_clk_i);
    hot_cause <= 1'b0;
    dl_down <= 1'b0;
    #1;
    chk({31'h0, rst_req.warm}, {31'h0, e});
  endtask
  task automatic end_sim();
    $display("counts checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(CTL, 32'h0);
    chk({29'h0, lock_we, pb_we, ld_sup}, 32'h0);
    config_requester_i.write(CTL, 32'h34);
    rd_chk(CTL, 32'h20);
    config_requester_i.write(CTL, 32'h38);
    rd_chk(CTL, 32'h28);
    config_requester_i.write(CTL, 32'h3C);
    rd_chk(CTL, 32'h38);
    for (i = 0; i < PBDV_COUNT; i++) begin
      pa = ADDR_W'(PBDV_BASE_OFF + 4 * i);
      config_requester_i.write(pa, DATA_W'(i) + 32'hA0);
      rd_chk(pa, DATA_W'(i) + 32'hA0);
    end
    config_requester_i.write(CTL, 32'h28);
    for (i = 0; i < PBDV_COUNT; i++) begin
      pa = ADDR_W'(PBDV_BASE_OFF + 4 * i);
      config_requester_i.write(pa, 32'h55);
      rd_chk(pa, DATA_W'(i) + 32'hA0);
    end
    rd_chk(12'h408, UNMAPPED_RD);
    $display("test unlock done");
    trig(32'h2A, 3'b011);
    trig(32'h29, 3'b100);
    rd_chk(CTL, 32'h28);
    pulse(1'b1, 1'b1);
    pulse(1'b0, 1'b0);
    config_requester_i.write(CTL, 32'h08);
    pulse(1'b0, 1'b1);
    $display("test reset causes done");
    config_requester_i.write(CTL, 32'h00);
    @(posedge sys_clk_i);
    seq_act <= 1'b1;
    @(posedge sys_clk_i);
    seq_act <= 1'b0;
    #1;
    chk({31'h0, lock_we}, 32'h1);
    config_requester_i.write(CTL, 32'h38);
    rd_chk(CTL, 32'h38);
    chk({29'h0, lock_we, pb_we, ld_sup}, 32'h7);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(CTL, 32'h0);
    chk({29'h0, lock_we, pb_we, ld_sup}, 32'h0);
    rd_chk(PBDV_BASE_OFF, PBDV_RST);
    $display("test fundamental reset done");
    end_sim();
  end
endmodule
`default_nettype wire
